// [rtl/trigger_counter_consts.svh]
`ifndef TRIGGER_COUNTER_CONSTS_SVH
`define TRIGGER_COUNTER_CONSTS_SVH

// upper half of the internal register window address
`define WIN_BASE 16'hFFFF

// register offsets inside the window
`define OFS_UNIT_SELECT 16'h0200
`define OFS_COUNT_WORD0 16'h0300
`define OFS_COUNT_WORD1 16'h0302
`define OFS_COUNT_WORD2 16'h0304
`define OFS_COUNT_WORD3 16'h0306
`define OFS_COUNT_LATCH 16'h030A
`define OFS_COUNTER_RESET 16'h6090

// stack launch unit settings, seen while a launch unit is selected
`define OFS_LAUNCH_STACK 16'h0300
`define OFS_LAUNCH_DELAY 16'h0302
`define OFS_LAUNCH_ENABLE 16'h0304

// unit numbers written to the unit select register
`define UNIT_COUNTER_FIRST 16'h0308
`define UNIT_LAUNCH_FIRST 16'h0280

// reset values
`define UNIT_SELECT_RESET 16'h0000
`define LAUNCH_DELAY_RESET 16'h0000
`define LAUNCH_STACK_RESET 3'h0

// sizes
`define NUM_COUNTERS 8
`define COUNT_WIDTH 64
`define NUM_LAUNCH 4
`define NUM_STACKS 3'h7

// timing: clock period in ns, added to the elapsed delay every cycle a launch unit waits
`define CLK_PERIOD_NS 17'h00014

`endif

// [rtl/trigger_counter_pkg.sv]
package trigger_counter_pkg;

    // one register access, taken in a single cycle
    typedef struct packed {
        logic wr;
        logic rd;
        logic [31:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    // settings of one stack launch unit
    typedef struct packed {
        logic enable;
        logic [2:0] stack;
        logic [15:0] delay_ns;
    } launch_cfg_t;

    typedef enum logic [1:0] {
        LAUNCH_IDLE = 2'b01,
        LAUNCH_WAIT = 2'b10
    } launch_state_t;

endpackage : trigger_counter_pkg

// [rtl/count_unit.sv]
`timescale 1ns/10ps
`include "trigger_counter_consts.svh"

module count_unit (
    input wire logic sys_clk, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire logic clear, // zero count and snapshot
    input wire logic sample_in, // counted signal, same clock domain
    input wire logic latch, // copy count into snapshot
    output logic [`COUNT_WIDTH-1:0] snap_q // latched count
);

    logic in_prev_q;
    logic [`COUNT_WIDTH-1:0] count_q;
    logic rise;

    assign rise = sample_in & ~in_prev_q;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            in_prev_q <= 1'b0;
        end else begin
            in_prev_q <= sample_in;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || clear) begin
            count_q <= {`COUNT_WIDTH{1'b0}};
        end else if (rise) begin
            count_q <= count_q + {{(`COUNT_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || clear) begin
            snap_q <= {`COUNT_WIDTH{1'b0}};
        end else if (latch) begin
            snap_q <= count_q;
        end
    end

endmodule : count_unit

// [rtl/trigger_counter.sv]
// Function
// - There are eight independent counters, each holding a 64-bit count.
// - A counter adds one on each rising edge of its input and ignores falling edges.
// - A latch copies the whole current count into the readable snapshot in one step.
// - The latch fires from a trigger-logic signal or from a write of 1 to the latch register.
// - Counters read as four 16-bit words at 0x0300..0x0306 in the window at 0xFFFF0000.
// - An activated stack launch unit starts one chosen stack out of seven.
// - A launch unit holds stack, enable and delay; disabled starts nothing, enabled waits.
// - Writing 1 to 0xFFFF6090 clears all counters to zero.
`timescale 1ns/10ps
`include "trigger_counter_consts.svh"

module trigger_counter (
    input wire logic sys_clk, // 50 MHz system clock
    input wire logic sys_rst, // synchronous reset, active high
    input trigger_counter_pkg::reg_req_t reg_req, // register access request
    output logic [15:0] reg_rdata_q, // read data
    output logic reg_rvalid_q, // read data valid pulse
    input wire logic [`NUM_COUNTERS-1:0] count_in, // counted signals
    input wire logic [`NUM_COUNTERS-1:0] count_latch_in, // latch from trigger logic
    input wire logic [`NUM_LAUNCH-1:0] launch_activate, // launch unit activation
    output logic [`NUM_LAUNCH-1:0] stack_start_q, // stack start pulses
    output logic [3*`NUM_LAUNCH-1:0] stack_start_index_q // stack number per launch unit
);

    import trigger_counter_pkg::*;

    // register window decode

    logic win_hit;
    logic [15:0] ofs;
    logic wr_hit;
    logic rd_hit;

    assign win_hit = (reg_req.addr[31:16] == `WIN_BASE);
    assign ofs = reg_req.addr[15:0];
    assign wr_hit = reg_req.wr & win_hit;
    assign rd_hit = reg_req.rd & win_hit;

    logic wr_unit_select;
    logic wr_latch;
    logic wr_counter_reset;
    logic wr_launch_stack;
    logic wr_launch_delay;
    logic wr_launch_enable;

    assign wr_unit_select = wr_hit & (ofs == `OFS_UNIT_SELECT);
    assign wr_latch = wr_hit & (ofs == `OFS_COUNT_LATCH) & reg_req.wdata[0];
    assign wr_counter_reset = wr_hit & (ofs == `OFS_COUNTER_RESET) & reg_req.wdata[0];

    // unit selection

    logic [15:0] unit_select_q;
    logic [15:0] ctr_offset;
    logic [15:0] launch_offset;
    logic ctr_selected;
    logic launch_selected;
    logic [2:0] ctr_idx;
    logic [1:0] launch_idx;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            unit_select_q <= `UNIT_SELECT_RESET;
        end else if (wr_unit_select) begin
            unit_select_q <= reg_req.wdata;
        end
    end

    assign ctr_offset = unit_select_q - `UNIT_COUNTER_FIRST;
    assign ctr_selected = (unit_select_q >= `UNIT_COUNTER_FIRST) &&
                          (ctr_offset < 16'(`NUM_COUNTERS));
    assign ctr_idx = ctr_offset[2:0];

    assign launch_offset = unit_select_q - `UNIT_LAUNCH_FIRST;
    assign launch_selected = (unit_select_q >= `UNIT_LAUNCH_FIRST) &&
                             (launch_offset < 16'(`NUM_LAUNCH));
    assign launch_idx = launch_offset[1:0];

    // launch settings share the word offsets, the selected unit tells them apart
    assign wr_launch_stack = wr_hit & launch_selected & (ofs == `OFS_LAUNCH_STACK);
    assign wr_launch_delay = wr_hit & launch_selected & (ofs == `OFS_LAUNCH_DELAY);
    assign wr_launch_enable = wr_hit & launch_selected & (ofs == `OFS_LAUNCH_ENABLE);

    // counters

    logic [`COUNT_WIDTH-1:0] snap [`NUM_COUNTERS];
    logic [`NUM_COUNTERS-1:0] latch_fire;

    genvar gc;
    generate
        for (gc = 0; gc < `NUM_COUNTERS; gc = gc + 1) begin : g_count
            assign latch_fire[gc] = count_latch_in[gc] |
                                    (wr_latch & ctr_selected & (ctr_idx == 3'(gc)));

            count_unit u_count (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .clear(wr_counter_reset),
                .sample_in(count_in[gc]),
                .latch(latch_fire[gc]),
                .snap_q(snap[gc])
            );
        end
    endgenerate

    // stack launch units

    launch_cfg_t launch_cfg_q [`NUM_LAUNCH];
    launch_state_t launch_state_q [`NUM_LAUNCH];
    logic [16:0] elapsed_q [`NUM_LAUNCH];
    logic [`NUM_LAUNCH-1:0] launch_go;
    logic [`NUM_LAUNCH-1:0] launch_due;
    logic [`NUM_LAUNCH-1:0] launch_valid_stack;

    genvar gl;
    generate
        for (gl = 0; gl < `NUM_LAUNCH; gl = gl + 1) begin : g_launch
            logic unit_wr;

            assign unit_wr = (launch_idx == 2'(gl));

            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    launch_cfg_q[gl].enable <= 1'b0;
                    launch_cfg_q[gl].stack <= `LAUNCH_STACK_RESET;
                    launch_cfg_q[gl].delay_ns <= `LAUNCH_DELAY_RESET;
                end else begin
                    if (wr_launch_stack && unit_wr) begin
                        launch_cfg_q[gl].stack <= reg_req.wdata[2:0];
                    end
                    if (wr_launch_delay && unit_wr) begin
                        launch_cfg_q[gl].delay_ns <= reg_req.wdata;
                    end
                    if (wr_launch_enable && unit_wr) begin
                        launch_cfg_q[gl].enable <= reg_req.wdata[0];
                    end
                end
            end

            assign launch_valid_stack[gl] = (launch_cfg_q[gl].stack < `NUM_STACKS);

            assign launch_go[gl] = launch_activate[gl] & launch_cfg_q[gl].enable &
                                   launch_valid_stack[gl];

            // delay counted in ns so any programmed value rounds up to whole cycles
            assign launch_due[gl] = (elapsed_q[gl] >= {1'b0, launch_cfg_q[gl].delay_ns});

            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    launch_state_q[gl] <= LAUNCH_IDLE;
                    elapsed_q[gl] <= 17'h00000;
                    stack_start_q[gl] <= 1'b0;
                    stack_start_index_q[3*gl +: 3] <= 3'h0;
                end else begin
                    stack_start_q[gl] <= 1'b0;
                    unique case (launch_state_q[gl])
                        LAUNCH_IDLE: begin
                            elapsed_q[gl] <= 17'h00000;
                            if (launch_go[gl]) begin
                                launch_state_q[gl] <= LAUNCH_WAIT;
                            end
                        end
                        LAUNCH_WAIT: begin
                            if (!launch_cfg_q[gl].enable) begin
                                // disabling cancels a pending start
                                launch_state_q[gl] <= LAUNCH_IDLE;
                            end else if (launch_due[gl]) begin
                                stack_start_q[gl] <= 1'b1;
                                stack_start_index_q[3*gl +: 3] <= launch_cfg_q[gl].stack;
                                launch_state_q[gl] <= LAUNCH_IDLE;
                            end else begin
                                elapsed_q[gl] <= elapsed_q[gl] + `CLK_PERIOD_NS;
                            end
                        end
                        default: begin
                            launch_state_q[gl] <= LAUNCH_IDLE;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // read path

    logic [`COUNT_WIDTH-1:0] snap_sel;
    logic [15:0] count_word;
    logic count_rd;
    logic [15:0] launch_word;
    logic launch_rd;
    logic [15:0] rdata_d;
    launch_cfg_t cfg_sel;

    assign snap_sel = snap[ctr_idx];
    assign cfg_sel = launch_cfg_q[launch_idx];

    assign count_rd = ctr_selected && (ofs[15:3] == 13'(`OFS_COUNT_WORD0 >> 3)) && !ofs[0];

    assign count_word = (ofs == `OFS_COUNT_WORD0) ? snap_sel[15:0] :
                        (ofs == `OFS_COUNT_WORD1) ? snap_sel[31:16] :
                        (ofs == `OFS_COUNT_WORD2) ? snap_sel[47:32] :
                        snap_sel[63:48];

    assign launch_rd = launch_selected &&
                       ((ofs == `OFS_LAUNCH_STACK) || (ofs == `OFS_LAUNCH_DELAY) ||
                        (ofs == `OFS_LAUNCH_ENABLE));

    assign launch_word = (ofs == `OFS_LAUNCH_STACK) ? {13'h0000, cfg_sel.stack} :
                         (ofs == `OFS_LAUNCH_DELAY) ? cfg_sel.delay_ns :
                         {15'h0000, cfg_sel.enable};

    // unmapped offsets and the write-only latch read as zero
    assign rdata_d = (ofs == `OFS_UNIT_SELECT) ? unit_select_q :
                     count_rd ? count_word :
                     launch_rd ? launch_word :
                     16'h0000;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata_q <= 16'h0000;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_req.rd;
            if (rd_hit) begin
                reg_rdata_q <= rdata_d;
            end else if (reg_req.rd) begin
                reg_rdata_q <= 16'h0000;
            end
        end
    end

endmodule : trigger_counter

// [sim/trigger_counter_monitor.sv]
`timescale 1ns/10ps
module trigger_counter_monitor (
    input wire logic sys_clk, // clock
    input wire logic sys_rst, // reset
    input trigger_counter_pkg::reg_req_t reg_req, // request
    input wire logic [15:0] reg_rdata_q, // read data
    input wire logic reg_rvalid_q, // read valid
    input wire logic [7:0] count_in, // counted inputs
    input wire logic [7:0] count_latch_in, // latches
    input wire logic [3:0] launch_activate, // activation
    input wire logic [3:0] stack_start_q, // starts
    input wire logic [11:0] stack_start_index_q // indexes
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    property p_rd_ans; reg_req.rd |=> reg_rvalid_q; endproperty
    property p_no_ans; !reg_req.rd |=> !reg_rvalid_q; endproperty
    property p_latch_rd;
        reg_req.rd && reg_req.addr == 32'hFFFF030A |=> reg_rdata_q == 16'h0000;
    endproperty
    property p_out_rd;
        reg_req.rd && reg_req.addr[31:16] != 16'hFFFF |=> reg_rdata_q == 16'h0000;
    endproperty
    property p_pulse;
        stack_start_q != 4'h0 |=> (stack_start_q & $past(stack_start_q)) == 4'h0;
    endproperty
    property p_idx; $changed(stack_start_index_q[2:0]) |-> stack_start_q[0]; endproperty
    property p_no7; stack_start_q[0] |-> stack_start_index_q[2:0] != 3'h7; endproperty
    property p_hold; $changed(reg_rdata_q) |-> reg_rvalid_q; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    a_no_ans: assert property (p_no_ans) else $error("answer without read");
    a_latch_rd: assert property (p_latch_rd) else $error("latch reg read not 0");
    a_out_rd: assert property (p_out_rd) else $error("outside read not 0");
    a_pulse: assert property (p_pulse) else $error("start pulse too long");
    a_idx: assert property (p_idx) else $error("index moved alone");
    a_no7: assert property (p_no7) else $error("stack 7 started");
    a_hold: assert property (p_hold) else $error("read data moved");
    c_rd: cover property (reg_rvalid_q);
    c_start: cover property (stack_start_q[0]);
    c_latch: cover property (reg_req.wr && reg_req.addr == 32'hFFFF030A);
endmodule : trigger_counter_monitor

bind trigger_counter trigger_counter_monitor trigger_counter_monitor_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .count_in(count_in), .count_latch_in(count_latch_in),
    .launch_activate(launch_activate), .stack_start_q(stack_start_q),
    .stack_start_index_q(stack_start_index_q));

// [sim/vme_master_model.sv]
`timescale 1ns/10ps
module vme_master_model (
    input wire logic sys_clk, // clock
    output trigger_counter_pkg::reg_req_t reg_req // request
);
    initial reg_req = '0;
    task acc(input logic w, input logic [31:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        reg_req = '{w, !w, a, d};
        @(negedge sys_clk);
        // released lines flip so a stale value never looks valid
        reg_req = '{1'b0, 1'b0, ~a, ~d};
    endtask : acc
endmodule : vme_master_model

// [sim/tb.sv]
`timescale 1ns/10ps
`include "trigger_counter_consts.svh"
module tb;
    import trigger_counter_pkg::*;
    logic sys_clk = 0;
    logic sys_rst = 1;
    reg_req_t reg_req;
    logic [15:0] reg_rdata_q;
    logic reg_rvalid_q;
    logic [7:0] count_in = 8'h00;
    logic [7:0] count_latch_in = 8'h00;
    logic [3:0] launch_activate = 4'h0;
    logic [3:0] stack_start_q;
    logic [11:0] stack_start_index_q;
    int fails = 0;
    int n_compared = 0;
    logic [15:0] exp_q[$];
    logic [63:0] cnt[8];
    logic [63:0] snap[8];
    logic [31:0] rs = 32'h3B0A;
    initial forever #10 sys_clk = ~sys_clk;
    trigger_counter trigger_counter_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reg_req(reg_req), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
        .count_in(count_in), .count_latch_in(count_latch_in),
        .launch_activate(launch_activate), .stack_start_q(stack_start_q),
        .stack_start_index_q(stack_start_index_q));
    vme_master_model vme_master_model_inst (.sys_clk(sys_clk), .reg_req(reg_req));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task end_sim;
        if (fails == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim
    task wr(input logic [15:0] a, input logic [15:0] d);
        vme_master_model_inst.acc(1'b1, {`WIN_BASE, a}, d);
    endtask : wr
    task rd(input logic [31:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        vme_master_model_inst.acc(1'b0, a, 16'h0000);
    endtask : rd
    task read_cnt(input int n, input logic [63:0] e, input logic latch);
        wr(`OFS_UNIT_SELECT, `UNIT_COUNTER_FIRST + n[15:0]);
        if (latch) wr(`OFS_COUNT_LATCH, 16'h0001);
        for (int i = 0; i < 4; i++) rd({`WIN_BASE, `OFS_COUNT_WORD0 + 16'(2 * i)}, e[16*i +: 16]);
    endtask : read_cnt
    task edges(input int cyc);
        repeat (cyc) begin
            @(negedge sys_clk);
            rs = xs(rs);
            for (int n = 0; n < 8; n++) cnt[n] += 64'(rs[n] & ~count_in[n]);
            count_in = rs[7:0];
        end
    endtask : edges
    task launch(input int u, input logic [2:0] s, input logic [15:0] d, input logic en);
        int k;
        wr(`OFS_UNIT_SELECT, `UNIT_LAUNCH_FIRST + u[15:0]);
        wr(`OFS_LAUNCH_STACK, {13'h0000, s});
        wr(`OFS_LAUNCH_DELAY, d);
        wr(`OFS_LAUNCH_ENABLE, {15'h0000, en});
        @(negedge sys_clk);
        launch_activate[u] = 1'b1;
        for (k = 1; k <= 40; k++) begin
            @(negedge sys_clk);
            launch_activate[u] = 1'b0;
            if (stack_start_q[u] === 1'b1) break;
        end
        // a disabled unit or stack 7 must run the loop out
        check(16'(k), (en && s != 3'h7) ? 16'(2 + (d + 19) / 20) : 16'd41);
        if (k <= 40) check({13'h0000, stack_start_index_q[3*u +: 3]}, {13'h0000, s});
    endtask : launch
    always @(negedge sys_clk) begin
        if (reg_rvalid_q === 1'b1) begin
            if (exp_q.size() == 0) fails++;
            else check(reg_rdata_q, exp_q.pop_front());
        end
    end
    initial begin
        #1ms;
        fails++;
        end_sim();
    end
    initial begin
        repeat (20) @(negedge sys_clk);
        sys_rst = 1'b0;
        for (int n = 0; n < 8; n++) cnt[n] = 64'h0;
        edges(200);
        for (int n = 0; n < 8; n++) read_cnt(n, cnt[n], 1'b1);
        @(negedge sys_clk);
        count_latch_in = 8'hFF;
        snap = cnt;
        @(negedge sys_clk);
        count_latch_in = 8'h00;
        edges(50);
        for (int n = 0; n < 8; n++) read_cnt(n, snap[n], 1'b0);
        rd({`WIN_BASE, `OFS_UNIT_SELECT}, `UNIT_COUNTER_FIRST + 16'h0007);
        rd({`WIN_BASE, `OFS_COUNT_LATCH}, 16'h0000);
        rd({16'h0000, `OFS_COUNT_WORD0}, 16'h0000);
        wr(`OFS_COUNTER_RESET, 16'h0001);
        read_cnt(3, 64'h0, 1'b1);
        for (int s = 0; s < 8; s++) begin
            rs = xs(rs);
            launch(s % 4, s[2:0], {9'h000, rs[6:0]}, 1'b1);
        end
        launch(1, 3'h2, 16'h0014, 1'b0);
        for (int k = 0; k < 20 && exp_q.size() > 0; k++) @(negedge sys_clk);
        if (exp_q.size() > 0) fails++;
        end_sim();
    end
endmodule : tb
